// ---- core/mta_consts.svh ----
// Offsets, field positions, reset values and timing counts for the
// measurement trigger and averaging block.
// Assumes a 50 MHz clock and a byte-addressed Avalon-MM register bus.
`ifndef MTA_CONSTS_SVH
`define MTA_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MTA_OFS_CTRL       5'h00
`define MTA_OFS_CMD        5'h04
`define MTA_OFS_DELAY      5'h08
`define MTA_OFS_AVG        5'h0C
`define MTA_OFS_STATUS     5'h10
`define MTA_OFS_RES_SUM    5'h14
`define MTA_OFS_RES_CNT    5'h18

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MTA_CTRL_EXT_BIT   0
`define MTA_CTRL_CONT_BIT  1
`define MTA_CMD_ARM_BIT    0
`define MTA_CMD_TRG_BIT    1
`define MTA_RST_EXT        1'h0
`define MTA_RST_CONT       1'h1
`define MTA_RST_DELAY_US   16'h1388
`define MTA_RST_AVG        9'h001
`define MTA_AVG_MAX        9'h100

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MTA_CLK_HZ         50000000
`define MTA_US_PER_S       1000000
`define MTA_CYC_PER_US     (`MTA_CLK_HZ / `MTA_US_PER_S)

`endif

// ---- core/mta_pkg.sv ----
// Types for the measurement trigger and averaging block.
// Assumes mta_consts.svh is the home of all numeric constants.
package mta_pkg;

	typedef enum logic [1:0]
	{
		MTA_IDLE   = 2'h0,
		MTA_DELAY  = 2'h1,
		MTA_SAMPLE = 2'h2
	} mta_state_type;

endpackage : mta_pkg

// ---- core/mta_core.sv ----
// Trigger sequencing, trigger delay, averaging and route reference flags.
// Assumes all inputs are synchronous to i_clk; the converter answers each
// o_sample_start pulse with one i_sample_valid pulse.
//
// Function
// - Internal source with continuation on measures continuously, self-triggered.
// - Internal source, continuation off: arm command gives one measurement, then disarm.
// - External source, continuation off: arm, then next trigger measures once, disarm.
// - External source, continuation on: every external trigger gives one measurement.
// - Continuation defaults on; only remote command access may clear it.
// - Continuation forced on at return to local and at power-up.
// - Trigger key starts a measurement when idle, aborts one in progress.
// - Start pin shorted to common triggers one measurement under external source.
// - Remote trigger command triggers one measurement under external source.
// - Internal source ignores key, start pin and remote trigger command.
// - Programmable delay between trigger and start of sampling.
// - Average count programmable from 1 to 256 readings.
// - Internal source: moving average if continuation on, block average if off.
// - External source always uses moving average.
// - Averaging cleared when conditions change: overrange or range switch.
// - After measurement error, averaging restarts once all readings recover.
// - Early results only for moving average in internal continuous mode.
// - High sense reading reference-only on source-high range or pair sum limits.
// - Low sense reading reference-only on source-low range or pair sum limits.
// - Both source readings reference-only when source pair sum over limit.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mta_consts.svh"

module mta_core #(
	parameter int P_CYC_PER_US = `MTA_CYC_PER_US
) (
	input  wire logic        i_clk,               // 50 MHz clock
	input  wire logic        i_rst,               // Async reset, high
	input  wire logic [4:0]  i_avs_address,       // Byte address
	input  wire logic        i_avs_read,          // Read request
	input  wire logic        i_avs_write,         // Write request
	input  wire logic [31:0] i_avs_writedata,     // Write data
	output logic      [31:0] o_avs_readdata,      // Read data
	output logic             o_avs_waitrequest,   // Stall bus
	input  wire logic        i_start_measure_pin_key,          // Key press pulse
	input  wire logic        i_start_measure_n,   // Start pin, low=shorted
	input  wire logic        i_remote,            // Remote control state
	input  wire logic [23:0] i_sample_data,       // Signed reading
	input  wire logic        i_sample_valid,      // Reading ready pulse
	input  wire logic        i_range_change,      // Range switched pulse
	input  wire logic        i_overrange,         // Overrange level
	input  wire logic        i_err_ohm,           // Resistance error
	input  wire logic        i_err_volt,          // Voltage error
	input  wire logic        i_src_hi_over_disp,  // Source hi over range
	input  wire logic        i_src_lo_over_disp,  // Source lo over range
	input  wire logic        i_sense_sum_over,    // Sense pair sum over
	input  wire logic        i_src_sum_over,      // Source pair sum over
	output logic             o_sample_start,      // Start converter pulse
	output logic             o_measuring,         // Measurement busy
	output logic             o_result_valid,      // Result pulse
	output logic      [31:0] o_result_sum,        // Sum of readings
	output logic      [8:0]  o_result_cnt,        // Readings in sum
	output logic             o_ref_sense_hi,      // Sense hi reference
	output logic             o_ref_sense_lo,      // Sense lo reference
	output logic             o_ref_src_hi,        // Source hi reference
	output logic             o_ref_src_lo         // Source lo reference
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	mta_pkg::mta_state_type state_reg;
	mta_pkg::mta_state_type state_next;
	logic        ext_reg;
	logic        cont_reg;
	logic [15:0] delay_us_reg;
	logic [8:0]  avg_reg;
	logic        armed_reg;
	logic        remote_q_reg;
	logic        pin_q_reg;
	logic [21:0] dly_cnt_reg;
	logic [31:0] sum_reg;
	logic [8:0]  fill_reg;
	logic [7:0]  wptr_reg;
	logic [23:0] ring [0:255];
	logic        bus_req;
	logic        bus_acc;
	logic        wr_ctrl;
	logic        wr_cmd;
	logic        arm_cmd;
	logic        trg_cmd;
	logic        ext_start_measure_pin;
	logic        start;
	logic        abort;
	logic        simple;
	logic        early;
	logic        avg_clear;
	logic        take;
	logic        full;
	logic [8:0]  fill_new;
	logic        meas_done;
	logic [31:0] sum_new;

	function automatic logic [31:0] sext(input logic [23:0] d);
		sext = {{8{d[23]}}, d};
	endfunction : sext

	function automatic logic [8:0] clamp_avg(input logic [31:0] v);
		if (v[31:0] == 32'h0)
			clamp_avg = 9'h001;
		else if (v > {23'h0, `MTA_AVG_MAX})
			clamp_avg = `MTA_AVG_MAX;
		else
			clamp_avg = v[8:0];
	endfunction : clamp_avg

	// ----------------------------------------------------------------
	// Bus slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	assign bus_req = i_avs_read | i_avs_write;
	assign bus_acc = bus_req & o_avs_waitrequest;
	assign wr_ctrl = bus_acc & i_avs_write & (i_avs_address == `MTA_OFS_CTRL);
	assign wr_cmd  = bus_acc & i_avs_write & (i_avs_address == `MTA_OFS_CMD);
	assign arm_cmd = wr_cmd & i_avs_writedata[`MTA_CMD_ARM_BIT];
	assign trg_cmd = wr_cmd & i_avs_writedata[`MTA_CMD_TRG_BIT];

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_avs_waitrequest <= 1'h1;
		else
			o_avs_waitrequest <= ~bus_acc;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_avs_readdata <= 32'h0;
		else if (bus_acc & i_avs_read)
		begin
			case (i_avs_address)
				`MTA_OFS_CTRL:    o_avs_readdata <= {30'h0, cont_reg, ext_reg};
				`MTA_OFS_DELAY:   o_avs_readdata <= {16'h0, delay_us_reg};
				`MTA_OFS_AVG:     o_avs_readdata <= {23'h0, avg_reg};
				`MTA_OFS_STATUS:  o_avs_readdata <= {19'h0, fill_reg,
					simple, armed_reg, state_reg};
				`MTA_OFS_RES_SUM: o_avs_readdata <= o_result_sum;
				`MTA_OFS_RES_CNT: o_avs_readdata <= {23'h0, o_result_cnt};
				default:          o_avs_readdata <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ext_reg      <= `MTA_RST_EXT;
			delay_us_reg <= `MTA_RST_DELAY_US;
			avg_reg      <= `MTA_RST_AVG;
		end
		else if (bus_acc & i_avs_write)
		begin
			if (i_avs_address == `MTA_OFS_CTRL)
				ext_reg <= i_avs_writedata[`MTA_CTRL_EXT_BIT];
			if (i_avs_address == `MTA_OFS_DELAY)
				delay_us_reg <= i_avs_writedata[15:0];
			if (i_avs_address == `MTA_OFS_AVG)
				avg_reg <= clamp_avg(i_avs_writedata);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			remote_q_reg <= 1'h0;
		else
			remote_q_reg <= i_remote;
	end

	// forced on at return to local
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			cont_reg <= `MTA_RST_CONT;
		else if (remote_q_reg & ~i_remote)
			cont_reg <= 1'h1;
		else if (wr_ctrl & (i_remote | i_avs_writedata[`MTA_CTRL_CONT_BIT]))
			cont_reg <= i_avs_writedata[`MTA_CTRL_CONT_BIT];
	end

	// ----------------------------------------------------------------
	// Trigger sources
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			pin_q_reg <= 1'h1;
		else
			pin_q_reg <= i_start_measure_n;
	end

	// external inputs only under external source
	// pin shorted; remote command; key when idle
	assign ext_start_measure_pin = ext_reg & ((pin_q_reg & ~i_start_measure_n) | trg_cmd
		| i_start_measure_pin_key);
	assign abort = ext_reg & i_start_measure_pin_key & (state_reg != mta_pkg::MTA_IDLE);

	always_comb
	begin
		start = 1'h0;
		if (state_reg == mta_pkg::MTA_IDLE)
		begin
			case ({ext_reg, cont_reg})
				2'h1:    start = 1'h1;
				2'h0:    start = armed_reg;
				2'h3:    start = ext_start_measure_pin;
				2'h2:    start = armed_reg & ext_start_measure_pin;
				default: start = 1'h0;
			endcase
		end
	end

	// arm, one measurement, disarm; set wins
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			armed_reg <= 1'h0;
		else if (arm_cmd & ~cont_reg)
			armed_reg <= 1'h1;
		else if (meas_done | cont_reg)
			armed_reg <= 1'h0;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign simple    = ~ext_reg & ~cont_reg;
	assign early     = ~ext_reg & cont_reg;
	assign take      = (state_reg == mta_pkg::MTA_SAMPLE) & i_sample_valid
		& ~abort;
	assign meas_done = take & (~simple | (fill_new == avg_reg));

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			mta_pkg::MTA_IDLE:
				if (start)
					state_next = mta_pkg::MTA_DELAY;
			mta_pkg::MTA_DELAY:
				if (abort)
					state_next = mta_pkg::MTA_IDLE;
				else if (dly_cnt_reg == 22'h0)
					state_next = mta_pkg::MTA_SAMPLE;
			mta_pkg::MTA_SAMPLE:
				if (abort | meas_done)
					state_next = mta_pkg::MTA_IDLE;
			default:
				state_next = mta_pkg::MTA_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			state_reg <= mta_pkg::MTA_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			dly_cnt_reg <= 22'h0;
		else if (start)
			dly_cnt_reg <= 22'(delay_us_reg * P_CYC_PER_US);
		else if (dly_cnt_reg != 22'h0)
			dly_cnt_reg <= dly_cnt_reg - 22'h1;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_sample_start <= 1'h0;
			o_measuring    <= 1'h0;
		end
		else
		begin
			o_sample_start <= ((state_reg == mta_pkg::MTA_DELAY)
				& (state_next == mta_pkg::MTA_SAMPLE))
				| (take & ~meas_done);
			o_measuring <= state_next != mta_pkg::MTA_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Averaging
	// ----------------------------------------------------------------
	// clear on changed conditions or while in error
	// block average restarts at each trigger
	assign avg_clear = i_range_change | i_overrange | i_err_ohm | i_err_volt
		| (simple & start);
	assign full      = fill_reg == avg_reg;
	assign fill_new  = full ? fill_reg : fill_reg + 9'h1;
	assign sum_new   = sum_reg + sext(i_sample_data)
		- (full ? sext(ring[wptr_reg]) : 32'h0);

	always_ff @(posedge i_clk)
	begin
		if (take)
			ring[wptr_reg] <= i_sample_data;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sum_reg  <= 32'h0;
			fill_reg <= 9'h0;
			wptr_reg <= 8'h0;
		end
		else if (avg_clear | (fill_reg > avg_reg))
		begin
			sum_reg  <= 32'h0;
			fill_reg <= 9'h0;
			wptr_reg <= 8'h0;
		end
		else if (take)
		begin
			sum_reg  <= sum_new;
			fill_reg <= fill_new;
			wptr_reg <= ({1'h0, wptr_reg} == avg_reg - 9'h1) ? 8'h0
				: wptr_reg + 8'h1;
		end
	end

	// early results only when internal continuous
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_result_valid <= 1'h0;
			o_result_sum   <= 32'h0;
			o_result_cnt   <= 9'h0;
		end
		else
		begin
			o_result_valid <= 1'h0;
			if (take & ~avg_clear & (early | (fill_new == avg_reg)))
			begin
				o_result_valid <= 1'h1;
				o_result_sum   <= sum_new;
				o_result_cnt   <= fill_new;
			end
		end
	end

	// ----------------------------------------------------------------
	// Route reference flags
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ref_sense_hi <= 1'h0;
			o_ref_sense_lo <= 1'h0;
			o_ref_src_hi   <= 1'h0;
			o_ref_src_lo   <= 1'h0;
		end
		else
		begin
			o_ref_sense_hi <= i_sense_sum_over | i_src_hi_over_disp
				| i_src_sum_over;
			o_ref_sense_lo <= i_sense_sum_over | i_src_lo_over_disp
				| i_src_sum_over;
			o_ref_src_hi <= i_src_sum_over;
			o_ref_src_lo <= i_src_sum_over;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_free_run_start: assert property (
		state_reg == mta_pkg::MTA_IDLE && !ext_reg && cont_reg
		|=> state_reg == mta_pkg::MTA_DELAY)
		else $error("free run did not restart");
	a_int_ignore_ext: assert property (
		state_reg == mta_pkg::MTA_IDLE && !ext_reg && !cont_reg && !armed_reg
		|=> state_reg == mta_pkg::MTA_IDLE)
		else $error("internal single mode started unarmed");
	a_ext_unarmed_idle: assert property (
		state_reg == mta_pkg::MTA_IDLE && ext_reg && !cont_reg && !armed_reg
		|=> state_reg == mta_pkg::MTA_IDLE)
		else $error("external single mode started unarmed");
	a_single_disarm: assert property (
		meas_done && !arm_cmd |=> !armed_reg)
		else $error("still armed after measurement");
	a_cont_local_on: assert property (
		$fell(i_remote) |=> cont_reg)
		else $error("continuation not forced on");
	a_cont_no_local: assert property (
		!i_remote && cont_reg |=> cont_reg)
		else $error("continuation cleared locally");
	a_key_abort: assert property (
		abort |=> state_reg == mta_pkg::MTA_IDLE && !o_measuring)
		else $error("key did not abort");
	a_delay_then_sample: assert property (
		state_reg == mta_pkg::MTA_DELAY && dly_cnt_reg == 22'h0 && !abort
		|=> o_sample_start && state_reg == mta_pkg::MTA_SAMPLE)
		else $error("sampling not started after delay");
	a_delay_waits: assert property (
		state_reg == mta_pkg::MTA_DELAY && dly_cnt_reg != 22'h0 && !abort
		|=> !o_sample_start)
		else $error("sampling started early");
	a_fill_bound: assert property (
		fill_reg <= `MTA_AVG_MAX && avg_reg != 9'h0
		&& avg_reg <= `MTA_AVG_MAX)
		else $error("fill beyond count");
	a_fill_shrink: assert property (
		fill_reg > avg_reg |=> fill_reg == 9'h0)
		else $error("fill not cleared after count change");
	a_clear_on_range: assert property (
		i_range_change |=> fill_reg == 9'h0)
		else $error("averaging not cleared");
	a_late_result: assert property (
		o_result_valid && !$past(early) |-> o_result_cnt == $past(avg_reg))
		else $error("early result outside internal continuous");
	a_src_ref_pair: assert property (
		i_src_sum_over |=> o_ref_src_hi && o_ref_src_lo && o_ref_sense_hi
		&& o_ref_sense_lo)
		else $error("source sum reference missing");

	c_free_run: cover property (
		!ext_reg && cont_reg && o_result_valid);
	c_ext_single: cover property (
		ext_reg && !cont_reg && meas_done);
	c_abort: cover property (abort);
	c_block_avg: cover property (
		simple && o_result_valid && o_result_cnt > 9'h1);

endmodule : mta_core
`default_nettype wire

// ---- tb/mta_adc_model.sv ----
// Converter model: answers each start pulse with one reading pulse.
// Assumes start is a one-cycle pulse on i_clk from the block under test.
`timescale 1ns/1ps
`default_nettype none

module mta_adc_model (
	input  wire logic        i_clk,    // System clock
	input  wire logic        i_rst,    // Async reset, high
	input  wire logic        i_start,  // Conversion start pulse
	input  wire logic        i_slow,   // Long conversion time
	input  wire logic [23:0] i_next,   // Reading to return
	output logic             o_valid,  // Reading ready pulse
	output logic      [23:0] o_data    // Reading
);
	int unsigned left;

	// ----------------------------------------------------------------
	// Conversion timer
	// ----------------------------------------------------------------
	// Data toggles when not valid so stale values never look good
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			left <= 0;
			o_valid <= 1'b0;
			o_data <= 24'h000000;
		end
		else
		begin
			o_valid <= 1'b0;
			o_data <= ~o_data;
			if (i_start)
				left <= i_slow ? 20 : 1;
			else if (left == 1)
			begin
				o_valid <= 1'b1;
				o_data <= i_next;
				left <= 0;
			end
			else if (left != 0)
				left <= left - 1;
		end
	end
endmodule : mta_adc_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the trigger and averaging block.
// Assumes mta_core with P_CYC_PER_US=1, so the delay register counts cycles.
`timescale 1ns/1ps
`default_nettype none
`include "mta_consts.svh"

module tb_top;
	logic        clk, rst, rd, wr, wreq, key, pin_n, remote, svalid;
	logic        rng, ovr, err_o, err_v, hi_od, lo_od, sns_sum, src_sum;
	logic        start, meas, rvalid, rsh, rsl, rxh, rxl, slow;
	logic [4:0]  addr;
	logic [31:0] wdata, rdata, rsum, last_sum;
	logic [23:0] sdata, next_data;
	logic [8:0]  rcnt, last_cnt;
	int          bad_count, checks_done, starts, results;

	mta_core #(.P_CYC_PER_US(1)) dut (.i_clk(clk), .i_rst(rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_start_measure_pin_key(key),
		.i_start_measure_n(pin_n), .i_remote(remote),
		.i_sample_data(sdata), .i_sample_valid(svalid),
		.i_range_change(rng), .i_overrange(ovr), .i_err_ohm(err_o),
		.i_err_volt(err_v), .i_src_hi_over_disp(hi_od),
		.i_src_lo_over_disp(lo_od), .i_sense_sum_over(sns_sum),
		.i_src_sum_over(src_sum), .o_sample_start(start),
		.o_measuring(meas), .o_result_valid(rvalid), .o_result_sum(rsum),
		.o_result_cnt(rcnt), .o_ref_sense_hi(rsh), .o_ref_sense_lo(rsl),
		.o_ref_src_hi(rxh), .o_ref_src_lo(rxl));

	mta_adc_model adc (.i_clk(clk), .i_rst(rst), .i_start(start),
		.i_slow(slow), .i_next(next_data), .o_valid(svalid),
		.o_data(sdata));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Event counters for starts and results
	always @(posedge clk)
	begin
		if (start === 1'b1)
			starts++;
		if (rvalid === 1'b1)
		begin
			results++;
			last_sum = rsum;
			last_cnt = rcnt;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic give_verdict;
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, exp, input string s);
		checks_done++;
		if (got !== exp)
		begin
			$display("ERROR %0t: %s got %h exp %h", $time, s, got, exp);
			bad_count++;
		end
	endtask : chk

	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= d;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		chk(n < 50, 1, "bus answer");
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg

	task automatic rchk(input logic [4:0] a, input logic [31:0] e,
		input string s);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(q, e, s);
	endtask : rchk

	task automatic pulse(input int which);
		@(posedge clk);
		if (which == 0)
			pin_n <= 1'b0;
		else if (which == 1)
			key <= 1'b1;
		else
			rng <= 1'b1;
		@(posedge clk);
		pin_n <= 1'b1;
		key <= 1'b0;
		rng <= 1'b0;
	endtask : pulse

	// One measurement: 0 pin, 1 key, 2 remote trigger command
	task automatic measure(input int how, input logic [23:0] d);
		int n;
		n = 0;
		next_data <= d;
		if (how == 2)
			wreg(`MTA_OFS_CMD, 32'h00000002);
		else
			pulse(how);
		repeat (4) @(posedge clk);
		while (meas !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk(n < 200, 1, "measure done");
		repeat (3) @(posedge clk);
	endtask : measure

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_free;
		int n;
		n = 0;
		rchk(`MTA_OFS_CTRL, 32'h00000002, "ctrl reset");
		rchk(`MTA_OFS_DELAY, 32'h00001388, "delay reset");
		rchk(`MTA_OFS_AVG, 32'h00000001, "avg reset");
		rchk(5'h1C, 32'h00000000, "unmapped read");
		wreg(`MTA_OFS_DELAY, 32'h00000008);
		wreg(`MTA_OFS_AVG, 32'h00000004);
		slow <= 1'b1;
		next_data <= 24'h000005;
		repeat (5100) @(posedge clk);
		pulse(2);
		results = 0;
		while (results == 0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		chk(results >= 1, 1, "early result");
		chk({23'h0, last_cnt}, 32'h00000001, "early count");
		chk(last_sum, 32'h00000005, "early sum");
		starts = 0;
		repeat (200) @(posedge clk);
		chk(starts >= 4, 1, "free run");
		slow <= 1'b0;
		$display("reset and free run done");
	endtask : t_reset_free

	task automatic t_cont_lock;
		wreg(`MTA_OFS_CTRL, 32'h00000000);
		rchk(`MTA_OFS_CTRL, 32'h00000002, "local clear");
		remote <= 1'b1;
		wreg(`MTA_OFS_CTRL, 32'h00000000);
		rchk(`MTA_OFS_CTRL, 32'h00000000, "remote clear");
		remote <= 1'b0;
		rchk(`MTA_OFS_CTRL, 32'h00000002, "back to local");
		$display("continuation lock done");
	endtask : t_cont_lock

	task automatic t_int_single;
		remote <= 1'b1;
		wreg(`MTA_OFS_CTRL, 32'h00000000);
		wreg(`MTA_OFS_AVG, 32'h00000002);
		repeat (60) @(posedge clk);
		starts = 0;
		results = 0;
		pulse(0);
		pulse(1);
		wreg(`MTA_OFS_CMD, 32'h00000002);
		repeat (60) @(posedge clk);
		chk(starts, 0, "internal ignores");
		// 10 ms delay, one cycle per microsecond here
		wreg(`MTA_OFS_DELAY, 32'h00002710);
		next_data <= 24'h000007;
		wreg(`MTA_OFS_CMD, 32'h00000001);
		repeat (10100) @(posedge clk);
		chk(starts, 2, "block starts");
		chk(results, 1, "block result");
		chk(last_sum, 32'h0000000E, "block sum");
		chk({23'h0, last_cnt}, 32'h00000002, "block count");
		rchk(`MTA_OFS_STATUS, 32'h00000028, "status idle");
		rchk(`MTA_OFS_RES_SUM, 32'h0000000E, "sum reg");
		rchk(`MTA_OFS_RES_CNT, 32'h00000002, "count reg");
		wreg(`MTA_OFS_DELAY, 32'h00000008);
		$display("internal single done");
	endtask : t_int_single

	task automatic t_ext_single;
		int n;
		n = 0;
		wreg(`MTA_OFS_CTRL, 32'h00000001);
		wreg(`MTA_OFS_AVG, 32'h00000001);
		starts = 0;
		results = 0;
		pulse(0);
		repeat (60) @(posedge clk);
		chk(starts, 0, "not armed");
		wreg(`MTA_OFS_CMD, 32'h00000001);
		@(posedge clk);
		pin_n <= 1'b0;
		@(posedge clk);
		while (start !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		pin_n <= 1'b1;
		chk(n >= 8 && n <= 10, 1, "trigger delay");
		repeat (40) @(posedge clk);
		chk(results, 1, "armed result");
		pulse(0);
		repeat (60) @(posedge clk);
		chk(starts, 1, "disarmed");
		$display("external single done");
	endtask : t_ext_single

	task automatic t_ext_cont;
		wreg(`MTA_OFS_CTRL, 32'h00000003);
		wreg(`MTA_OFS_AVG, 32'h00000003);
		pulse(2);
		results = 0;
		measure(2, 24'h00000A);
		measure(1, 24'h000014);
		chk(results, 0, "not full yet");
		measure(0, 24'h00001E);
		chk(last_sum, 32'h0000003C, "full sum");
		measure(0, 24'h000028);
		chk(last_sum, 32'h0000005A, "moving sum");
		chk({23'h0, last_cnt}, 32'h00000003, "moving count");
		starts = 0;
		pulse(1);
		repeat (2) @(posedge clk);
		pulse(1);
		repeat (40) @(posedge clk);
		chk(starts, 0, "abort start");
		chk(meas, 1'b0, "abort idle");
		$display("external continuous done");
	endtask : t_ext_cont

	task automatic t_errors;
		results = 0;
		err_o <= 1'b1;
		err_v <= 1'b1;
		measure(0, 24'h000032);
		err_o <= 1'b0;
		measure(0, 24'h000037);
		err_v <= 1'b0;
		measure(0, 24'h00003C);
		measure(0, 24'h000046);
		chk(results, 0, "restart fill");
		measure(0, 24'h000050);
		chk(results, 1, "restart result");
		chk(last_sum, 32'h000000D2, "restart sum");
		ovr <= 1'b1;
		measure(0, 24'h000001);
		ovr <= 1'b0;
		chk(results, 1, "overrange clear");
		$display("error restart done");
	endtask : t_errors

	task automatic t_flags;
		logic [3:0] f;
		for (int i = 0; i < 16; i++)
		begin
			f = 4'(i);
			@(posedge clk);
			{src_sum, sns_sum, lo_od, hi_od} <= f;
			repeat (3) @(posedge clk);
			chk(rsh, f[0] | f[2] | f[3], "sense hi ref");
			chk(rsl, f[1] | f[2] | f[3], "sense lo ref");
			chk({rxh, rxl}, {2{f[3]}}, "source refs");
		end
		$display("reference flags done");
	endtask : t_flags

	initial
	begin
		{rd, wr, key, rng, ovr, err_o, err_v, remote, slow} = 9'h000;
		{hi_od, lo_od, sns_sum, src_sum} = 4'h0;
		{pin_n, rst} = 2'h3;
		addr = 5'h00;
		wdata = 32'h00000000;
		next_data = 24'h000000;
		{bad_count, checks_done, starts, results} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset_free();
		t_cont_lock();
		t_int_single();
		t_ext_single();
		t_ext_cont();
		t_errors();
		t_flags();
		give_verdict();
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (40000) @(posedge clk);
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule : tb_top

`default_nettype wire
